// *** src/pwm_steer_map.svh ***
/*
  register offsets, field positions, reset values and timing counts
  for the pwm dead-band and steering output stage.
  assumes inclusion by bare name from the design file.
*/
`ifndef PWM_STEER_MAP_SVH
`define PWM_STEER_MAP_SVH
// register offsets (word index on the plain register port)
`define OFS_CAPTURE_PWM_CTL 3'h0
`define OFS_SHUTDOWN_CTL 3'h1
`define OFS_STEERING_CTL 3'h2
`define OFS_DEADBAND_RESTART_CTL 3'h3
`define OFS_ALT_PIN_SELECT 3'h4
`define OFS_PERIPH_FLAG_REG 3'h5
`define OFS_IRQ_MASK 3'h6
// reset values
`define RST_CAPTURE_PWM_CTL 8'h00
`define RST_SHUTDOWN_CTL 8'h00
`define RST_STEERING_CTL 8'h01
`define RST_DEADBAND_RESTART_CTL 8'h00
`define RST_ALT_PIN_SELECT 8'h00
`define RST_IRQ_MASK 2'h0
// field positions
`define POS_SHUTDOWN_EVENT 7
`define POS_RESTART_EN 7
`define POS_STEER_SYNC 4
`define POS_STEER_B 1
`define POS_STEER_A 0
`define POS_ALT_OUT_B 1
`define POS_ALT_OUT_A 0
`define POS_FLAG_PERIOD 1
`define POS_FLAG_SHUTDOWN 0
`define STEER_WR_MASK 8'h13
// mode codes
`define MODE_PWM_HI 2'h3
`define CFG_SINGLE 2'h0
`define CFG_HALF_BRIDGE 2'h2
// one instruction cycle is four oscillator periods
`define TOSC_PER_TCY 4
`endif

// *** src/pwm_steer_pkg.sv ***
/*
  types for the pwm dead-band and steering output stage.
  assumes no other package.
*/
`default_nettype none
package pwm_steer_pkg;
  typedef enum logic [1:0] {
    OUT_OFF = 2'h0,
    OUT_SINGLE = 2'h1,
    OUT_HALF = 2'h3
  } out_mode_t;
endpackage
`default_nettype wire

// *** src/pwm_deadband_steering.sv ***
/*
  output stage of the enhanced pwm: dead-band delay, steering,
  per-pin polarity, auto-shutdown pin forcing, period flag, interrupt.
  assumes an external time base supplies the raw pwm level and a
  one-cycle period-start pulse, and tcy_tick marks instruction cycles;
  fault_in is an asynchronous pin.
*/
// The strobed register port and the register offsets are this design's own decisions.
`default_nettype none
`include "pwm_steer_map.svh"
module pwm_deadband_steering #(
  parameter int DB_W = 7 // dead-band count width
) (
  input wire logic clk_sys, // system clock, 20 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic [2:0] reg_addr, // register index
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic pwm_raw, // raw pwm from time base, same domain
  input wire logic period_start, // one-cycle pulse at period start
  input wire logic tcy_tick, // one pulse per instruction cycle
  input wire logic fault_in, // shutdown request pin, async
  input wire logic [1:0] port_out, // port latch data for a and b
  input wire logic [1:0] port_dir, // pin direction, 0 = output
  output logic [3:0] pin_out, // levels: a main, b main, a alt, b alt
  output logic [3:0] pin_oe, // output enables, same order
  output logic irq // level interrupt
);
  ////////////////////////////////////////////////////////////////////
  // registers and synchroniser
  logic [7:0] ccp_ctl_ff, sd_ctl_ff, steer_ctl_ff, db_ctl_ff, alt_ff;
  logic [1:0] steer_act_ff, flags_ff, mask_ff;
  logic [1:0] fault_sync_ff;
  logic [1:0] per_cnt_ff;
  logic [1:0] ccp_mode_select, output_config_select;
  logic [DB_W-1:0] deadband_count;
  logic steer_sync_select, restart_en, sd_event;
  pwm_steer_pkg::out_mode_t mode;
  logic fault_lvl;

  assign ccp_mode_select = ccp_ctl_ff[1:0];
  assign output_config_select = ccp_ctl_ff[7:6];
  assign deadband_count = db_ctl_ff[DB_W-1:0];
  assign steer_sync_select = steer_ctl_ff[`POS_STEER_SYNC];
  assign restart_en = db_ctl_ff[`POS_RESTART_EN];
  assign sd_event = sd_ctl_ff[`POS_SHUTDOWN_EVENT];
  // fault is low-active at the pin; source select nonzero enables it
  assign fault_lvl = !fault_sync_ff[1] && (sd_ctl_ff[6:4] != 3'h0);

  // mode decode
  always_comb begin
    mode = pwm_steer_pkg::OUT_OFF;
    if (ccp_ctl_ff[3:2] == `MODE_PWM_HI) begin
      if (output_config_select == `CFG_SINGLE) begin
        mode = pwm_steer_pkg::OUT_SINGLE;
      end else if (output_config_select == `CFG_HALF_BRIDGE) begin
        mode = pwm_steer_pkg::OUT_HALF;
      end
    end
  end

  // two-flop synchroniser for the fault pin
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fault_sync_ff <= 2'h3;
    end else begin
      fault_sync_ff <= {fault_sync_ff[0], fault_in};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ccp_ctl_ff <= `RST_CAPTURE_PWM_CTL;
      steer_ctl_ff <= `RST_STEERING_CTL;
      db_ctl_ff <= `RST_DEADBAND_RESTART_CTL;
      alt_ff <= `RST_ALT_PIN_SELECT;
      mask_ff <= `RST_IRQ_MASK;
    end else if (reg_wr) begin
      if (reg_addr == `OFS_CAPTURE_PWM_CTL) begin
        ccp_ctl_ff <= reg_wdata;
      end else if (reg_addr == `OFS_STEERING_CTL) begin
        steer_ctl_ff <= reg_wdata & `STEER_WR_MASK;
      end else if (reg_addr == `OFS_DEADBAND_RESTART_CTL) begin
        db_ctl_ff <= reg_wdata;
      end else if (reg_addr == `OFS_ALT_PIN_SELECT) begin
        alt_ff <= reg_wdata;
      end else if (reg_addr == `OFS_IRQ_MASK) begin
        mask_ff <= reg_wdata[1:0];
      end
    end
  end

  // shutdown control: event bit set by fault, held while fault persists
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sd_ctl_ff <= `RST_SHUTDOWN_CTL;
    end else begin
      if (reg_wr && reg_addr == `OFS_SHUTDOWN_CTL) begin
        sd_ctl_ff[6:0] <= reg_wdata[6:0];
      end
      if (fault_lvl) begin
        sd_ctl_ff[`POS_SHUTDOWN_EVENT] <= 1'b1;
      end else if (reg_wr && reg_addr == `OFS_SHUTDOWN_CTL) begin
        sd_ctl_ff[`POS_SHUTDOWN_EVENT] <= reg_wdata[7];
      end else if (restart_en && period_start) begin
        sd_ctl_ff[`POS_SHUTDOWN_EVENT] <= 1'b0; // auto-restart
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // active steering: immediate or at next period start
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      steer_act_ff <= 2'(`RST_STEERING_CTL);
    end else if (!steer_sync_select) begin
      steer_act_ff <= steer_ctl_ff[1:0];
    end else if (period_start) begin
      steer_act_ff <= steer_ctl_ff[1:0];
    end
  end

  // period counter and flags; set wins over read-clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      per_cnt_ff <= 2'h0;
    end else if (mode == pwm_steer_pkg::OUT_OFF) begin
      per_cnt_ff <= 2'h0;
    end else if (period_start && per_cnt_ff != 2'h2) begin
      per_cnt_ff <= per_cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_ff <= 2'h0;
    end else begin
      if (reg_rd && reg_addr == `OFS_PERIPH_FLAG_REG) begin
        flags_ff <= 2'h0;
      end
      // second period start marks first full cycle done
      if (period_start && per_cnt_ff == 2'h1) begin
        flags_ff[`POS_FLAG_PERIOD] <= 1'b1;
      end
      if (fault_lvl && !sd_event) begin
        flags_ff[`POS_FLAG_SHUTDOWN] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_ff & mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // dead-band: per output, delay rising edge of the active level
  logic [1:0] sched, delayed, pwm_en, shut_val, shut_tri, lvl, pol_lo;
  logic [DB_W-1:0] db_cnt_ff [2];
  logic [1:0] sched_q_ff, dly_ff;

  assign sched = {!pwm_raw, pwm_raw};
  assign pol_lo = {ccp_mode_select[0], ccp_mode_select[1]};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_out
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          db_cnt_ff[gi] <= '0;
          dly_ff[gi] <= 1'b0;
          sched_q_ff[gi] <= 1'b0;
        end else begin
          sched_q_ff[gi] <= sched[gi];
          if (!sched[gi]) begin
            dly_ff[gi] <= 1'b0;
            db_cnt_ff[gi] <= '0;
          end else if (!sched_q_ff[gi]) begin
            db_cnt_ff[gi] <= deadband_count;
            dly_ff[gi] <= (deadband_count == '0);
          end else if (db_cnt_ff[gi] != '0) begin
            if (tcy_tick) begin
              db_cnt_ff[gi] <= db_cnt_ff[gi] - DB_W'(1);
              dly_ff[gi] <= (db_cnt_ff[gi] == DB_W'(1));
            end
          end
        end
      end
      // falling scheduled edge drops at once, a stale dly_ff cannot
      // stretch it; only the rising edge waits for the count
      assign delayed[gi] = (mode == pwm_steer_pkg::OUT_HALF) ?
        (sched[gi] && (dly_ff[gi] || deadband_count == '0)) :
        pwm_raw;
      assign shut_val[gi] = sd_ctl_ff[2*(1-gi)];
      assign shut_tri[gi] = sd_ctl_ff[2*(1-gi)+1];
    end
  endgenerate

  always_comb begin
    pwm_en = 2'h0;
    if (mode == pwm_steer_pkg::OUT_HALF) begin
      pwm_en = 2'h3;
    end else if (mode == pwm_steer_pkg::OUT_SINGLE) begin
      pwm_en = steer_act_ff;
    end
  end

  // output pins: pwm, shutdown state, or port latch; alt select moves
  logic [1:0] o_lvl, o_en;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      lvl[i] = delayed[i] ^ pol_lo[i];
      o_lvl[i] = port_out[i];
      o_en[i] = !port_dir[i];
      if (pwm_en[i] && sd_event) begin
        o_lvl[i] = shut_val[i];
        o_en[i] = !shut_tri[i];
      end else if (pwm_en[i]) begin
        o_lvl[i] = lvl[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_out <= 4'h0;
      pin_oe <= 4'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        pin_out[i] <= alt_ff[i] ? 1'b0 : o_lvl[i];
        pin_oe[i] <= alt_ff[i] ? 1'b0 : o_en[i];
        pin_out[i+2] <= alt_ff[i] ? o_lvl[i] : 1'b0;
        pin_oe[i+2] <= alt_ff[i] ? o_en[i] : 1'b0;
      end
    end
  end

  // read data
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == `OFS_CAPTURE_PWM_CTL) begin
      reg_rdata <= ccp_ctl_ff;
    end else if (reg_addr == `OFS_SHUTDOWN_CTL) begin
      reg_rdata <= sd_ctl_ff;
    end else if (reg_addr == `OFS_STEERING_CTL) begin
      reg_rdata <= steer_ctl_ff;
    end else if (reg_addr == `OFS_DEADBAND_RESTART_CTL) begin
      reg_rdata <= db_ctl_ff;
    end else if (reg_addr == `OFS_ALT_PIN_SELECT) begin
      reg_rdata <= alt_ff;
    end else if (reg_addr == `OFS_PERIPH_FLAG_REG) begin
      reg_rdata <= {6'h00, flags_ff};
    end else if (reg_addr == `OFS_IRQ_MASK) begin
      reg_rdata <= {6'h00, mask_ff};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  chk_falling_undelayed: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (mode == pwm_steer_pkg::OUT_HALF && !sched[0] && !sd_event &&
     !alt_ff[0])
    |=> pin_out[0] == $past(pol_lo[0]))
    else $error("half-bridge falling edge was delayed");
  chk_zero_no_delay: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (mode == pwm_steer_pkg::OUT_HALF && deadband_count == '0 &&
     sched[1] && !sd_event && !alt_ff[1])
    |=> pin_out[1] != $past(pol_lo[1]))
    else $error("zero dead-band still delayed");
  chk_sync_apply: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (steer_sync_select && !period_start) |=> $stable(steer_act_ff))
    else $error("synced steering changed mid period");
  chk_immediate_apply: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    !steer_sync_select |=> steer_act_ff == $past(steer_ctl_ff[1:0]))
    else $error("immediate steering not applied");
  chk_shut_only_en: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (!pwm_en[0] && !alt_ff[0]) |=> pin_out[0] == $past(port_out[0]))
    else $error("non-steered pin disturbed");
  chk_period_flag: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (period_start && per_cnt_ff == 2'h1 && mode != pwm_steer_pkg::OUT_OFF)
    |=> flags_ff[`POS_FLAG_PERIOD])
    else $error("period flag not set on second period");
  chk_complement: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (mode == pwm_steer_pkg::OUT_HALF && deadband_count == '0 &&
     !sd_event && alt_ff[1:0] == 2'h0 && pol_lo == 2'h0)
    |=> pin_out[1] == !pin_out[0])
    else $error("b not complement of a");
  chk_irq_level: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    |(flags_ff & mask_ff) |=> irq)
    else $error("irq missing");
  // a fresh rising edge with a nonzero count must not reach the pin yet
  chk_rise_held: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (mode == pwm_steer_pkg::OUT_HALF && sched[0] && !sched_q_ff[0] &&
     deadband_count != '0 && !sd_event && !alt_ff[0])
    |=> pin_out[0] == $past(pol_lo[0]))
    else $error("half-bridge rising edge not delayed");
  // an enabled pin in shutdown shows its programmed shutdown state
  chk_shut_forced: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (pwm_en[0] && sd_event && !alt_ff[0])
    |=> pin_out[0] == $past(shut_val[0]) &&
        pin_oe[0] == !$past(shut_tri[0]))
    else $error("enabled pin not forced in shutdown");
  // an unsteered pin in single mode is plain port control
  chk_unsteered_port: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (mode == pwm_steer_pkg::OUT_SINGLE && !pwm_en[1] && !alt_ff[1])
    |=> pin_out[1] == $past(port_out[1]) &&
        pin_oe[1] == !$past(port_dir[1]))
    else $error("unsteered pin left port control");
endmodule
`default_nettype wire

// *** bench/half_bridge_stage.sv ***
/*
  behavioural half-bridge switch stage hanging on pins a and b.
  assumes pull-downs hold each gate off while its pin is undriven.
*/
`default_nettype none
module half_bridge_stage (
  input wire logic clk_sys, // sampling clock
  input wire logic [1:0] drive_lvl, // pin levels, a and b
  input wire logic [1:0] drive_oe, // pin output enables
  output logic hi_on, // upper switch conducting
  output logic lo_on, // lower switch conducting
  output var int shoot_cycles // cycles with both switches on
);
  // pull-down turns an undriven pin into an off gate
  assign hi_on = drive_oe[0] & drive_lvl[0];
  assign lo_on = drive_oe[1] & drive_lvl[1];
  // count cycles of overlap, the hazard dead-band exists for
  initial shoot_cycles = 0;
  always @(posedge clk_sys) begin
    if (hi_on && lo_on) begin
      shoot_cycles <= shoot_cycles + 1;
    end
  end
endmodule
`default_nettype wire

// *** bench/pwm_deadband_steering_tb.sv ***
/*
  self-checking bench: reset, period flag, then steering table, sync,
  alternate pins, dead-band and shutdown with interrupt.
  assumes the design files and the switch stage compile first.
*/
`default_nettype none
module pwm_deadband_steering_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic pwm_raw = 1'b0;
  logic period_start = 1'b0;
  logic tcy_tick = 1'b0;
  logic fault_in = 1'b1;
  logic [1:0] port_out = 2'h0;
  logic [1:0] port_dir = 2'h3;
  logic [3:0] pin_out;
  logic [3:0] pin_oe;
  logic irq;
  logic [1:0] tick_cnt = 2'h0;
  logic [7:0] rv;
  logic hi_on;
  logic lo_on;
  logic seen;
  int shoot_cycles;
  int shoot_base;
  int n_fail = 0;
  int samples_checked = 0;
  // mode, steering, raw level, port latch and expected pins {b,a}
  logic [15:0] rows [10] = '{16'h0313, 16'h0300, 16'h1311, 16'h2312,
    16'h3310, 16'h3303, 16'h011B, 16'h0212, 16'h0015, 16'h110A};

  pwm_deadband_steering dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_raw(pwm_raw),
    .period_start(period_start), .tcy_tick(tcy_tick),
    .fault_in(fault_in), .port_out(port_out), .port_dir(port_dir),
    .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
  half_bridge_stage bridge (.clk_sys(clk_sys), .drive_lvl(pin_out[1:0]),
    .drive_oe(pin_oe[1:0]), .hi_on(hi_on), .lo_on(lo_on),
    .shoot_cycles(shoot_cycles));

  ////////////////////////////////////////////////////////////////////////
  // clock and one instruction-cycle tick every four clocks
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    tick_cnt <= tick_cnt + 2'h1;
    tcy_tick <= (tick_cnt == 2'h3);
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse();
    @(posedge clk_sys);
    period_start <= 1'b1;
    @(posedge clk_sys);
    period_start <= 1'b0;
  endtask
  task automatic set_raw(input logic v);
    @(posedge clk_sys);
    pwm_raw <= v;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle(1);
    chk("pin_oe", 8'h00, {4'h0, pin_oe});
    chk("irq", 8'h00, {7'h00, irq});
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], rv);
      chk("reset value", (i == 2) ? 8'h01 : 8'h00, rv);
    end
    wr(3'h2, 8'hFF);
    rd(3'h2, rv);
    chk("steering bits", 8'h13, rv);
    wr(3'h0, 8'h0C);
    pulse();
    settle(2);
    rd(3'h5, rv);
    chk("first period", 8'h00, {7'h00, rv[1]});
    pulse();
    settle(2);
    rd(3'h5, rv);
    chk("second period", 8'h01, {7'h00, rv[1]});
    rd(3'h5, rv);
    chk("flag cleared", 8'h00, {7'h00, rv[1]});
    @(posedge clk_sys);
    port_dir <= 2'h0;
    foreach (rows[i]) begin
      wr(3'h0, {6'h03, rows[i][13:12]});
      wr(3'h2, {6'h00, rows[i][9:8]});
      @(posedge clk_sys);
      pwm_raw <= rows[i][4];
      port_out <= rows[i][3:2];
      pulse();
      settle(3);
      chk("steered", {6'h00, rows[i][1:0]}, {6'h00, pin_out[1:0]});
    end
    wr(3'h0, 8'h0C);
    wr(3'h2, 8'h03);
    set_raw(1'b1);
    port_out <= 2'h0;
    pulse();
    wr(3'h2, 8'h11);
    settle(3);
    chk("sync held", 8'h03, {6'h00, pin_out[1:0]});
    pulse();
    settle(3);
    chk("sync applied", 8'h01, {6'h00, pin_out[1:0]});
    wr(3'h2, 8'h02);
    settle(3);
    chk("immediate", 8'h02, {6'h00, pin_out[1:0]});
    wr(3'h2, 8'h01);
    wr(3'h4, 8'h01);
    settle(3);
    chk("alt enables", 8'h06, {4'h0, pin_oe});
    chk("alt level", 8'h01, {6'h00, pin_out[3:2]});
    wr(3'h4, 8'h00);
    // half bridge with a three-tick dead band
    shoot_base = shoot_cycles;
    wr(3'h0, 8'h8C);
    wr(3'h3, 8'h03);
    set_raw(1'b0);
    pulse();
    settle(40);
    chk("hb idle", 8'h02, {6'h00, pin_out[1:0]});
    set_raw(1'b1);
    settle(6);
    chk("rise delayed", 8'h00, {6'h00, pin_out[1:0]});
    settle(18);
    chk("rise done", 8'h01, {6'h00, pin_out[1:0]});
    set_raw(1'b0);
    settle(6);
    chk("fall at once", 8'h00, {6'h00, pin_out[1:0]});
    settle(18);
    chk("b delayed", 8'h02, {6'h00, pin_out[1:0]});
    wr(3'h3, 8'h00);
    set_raw(1'b1);
    settle(3);
    chk("zero count", 8'h01, {6'h00, pin_out[1:0]});
    wr(3'h3, 8'h0A);
    set_raw(1'b0);
    settle(60);
    seen = 1'b0;
    set_raw(1'b1);
    repeat (20) begin
      settle(1);
      seen = seen | pin_out[0];
    end
    set_raw(1'b0);
    repeat (20) begin
      settle(1);
      seen = seen | pin_out[0];
    end
    chk("over duty", 8'h00, {7'h00, seen});
    chk("shoot", 8'h00, {7'h00, shoot_cycles != shoot_base});
    // shutdown of the steered pin only, then interrupt
    wr(3'h0, 8'h0C);
    wr(3'h3, 8'h00);
    wr(3'h2, 8'h01);
    wr(3'h6, 8'h00);
    port_out <= 2'h2;
    pulse();
    wr(3'h1, 8'h44);
    @(posedge clk_sys);
    fault_in <= 1'b0;
    settle(6);
    chk("shutdown pins", 8'h03, {6'h00, pin_out[1:0]});
    @(posedge clk_sys);
    fault_in <= 1'b1;
    // let the fault leave the synchroniser, else the clear is refused
    settle(3);
    wr(3'h1, 8'h44);
    settle(4);
    chk("restarted", 8'h02, {6'h00, pin_out[1:0]});
    chk("irq masked", 8'h00, {7'h00, irq});
    wr(3'h6, 8'h01);
    settle(2);
    chk("irq raised", 8'h01, {7'h00, irq});
    rd(3'h5, rv);
    chk("event flag", 8'h01, {7'h00, rv[0]});
    settle(2);
    chk("irq cleared", 8'h00, {7'h00, irq});
    // mid-run reset releases every pin and restores steering to a
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    settle(3);
    chk("reset pins", 8'h00, {pin_oe, pin_out});
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(3'h2, rv);
    chk("reset steering", 8'h01, rv);
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////
  // watchdog cuts a hang short
  initial begin
    #2000000;
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
